// File: core/sys_config_cfg.svh
// Constants for the system configuration register block.
// Assumes a 125 MHz system clock and a 16-bit register address port.
//
// Summary of operation
// R01: Straps load memory, byte-high and write fields.
// R02: Writes ignored after end-of-init instruction.
// R03: Share bit lets external master reach peripherals.
// R04: Visible bit mirrors peripheral accesses on pins.
// R05: Enable bit gates extension peripherals and RAM.
// R06: Bidirectional reset off: reset pin input only.
// R07: Bidirectional reset on: drive pin 1024 half-clocks.
// R08: Watchdog on, bypassed: no crystal 1us, use PLL.
// R09: Watchdog off, bypassed: crystal clock, PLL off.
// R10: Power-down mode 0: needs NMI low, reset exits.
// R11: Power-down mode 1: irq pins idle, irq exits.
// R12: Latched chip selects change after ALE rise.
// R13: Write config turns pins into byte strobes.
// R14: Write config is inverse of strap bit.
// R15: Clock enable puts system clock on pin.
// R16: Byte-high disable releases pin, strap initialised.
// R17: Memory enable serves internal area, else external.
// R18: Segmentation disable saves instruction pointer only.
// R19: Mapping bit selects segment 0 or 1.
// R20: Stack size field selects 32 to 1024 words.
// R21: Stack size codes map to fixed sizes.
`ifndef SYS_CONFIG_CFG_SVH
`define SYS_CONFIG_CFG_SVH

`define SYS_CONFIG_OFFSET 16'hFF12
`define SYS_CONFIG_RESET 16'h0000
`define SYS_CONFIG_WRITE_MASK 16'hF9FF
`define STRAP_WRC_BIT 5
`define STRAP_BUS_WIDTH_BIT 7
`define CLK_PERIOD_NS 8
`define HALF_CLK_NS 4
`define RESET_DRIVE_TCL 1024
`define RESET_DRIVE_CYCLES \
  ((`RESET_DRIVE_TCL * `HALF_CLK_NS) / `CLK_PERIOD_NS)
`define OSC_TIMEOUT_NS 1000
`define OSC_TIMEOUT_CYCLES \
  ((`OSC_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MEM_AREA_LAST 16'h7FFF

`endif

// File: core/sys_config_pkg.sv
// Types shared by the system configuration register block.
// Assumes nothing beyond a SystemVerilog compiler.
package sys_config_pkg;

  typedef struct packed {
    logic [2:0] stack_size_sel;
    logic       internal_mem_segment_sel;
    logic       segmentation_disable;
    logic       internal_mem_enable;
    logic       byte_high_disable;
    logic       clock_output_enable;
    logic       write_strobe_config;
    logic       chip_select_config;
    logic       power_down_config;
    logic       osc_watchdog_disable;
    logic       bidir_reset_enable;
    logic       ext_periph_enable;
    logic       visible_mode;
    logic       ext_periph_share;
  } sys_cfg_s;

  typedef enum logic [0:0] {
    PD_RUN  = 1'b0,
    PD_DOWN = 1'b1
  } pd_state_e;

endpackage

// File: core/system_configuration.sv
// System configuration register with the pin and clock controls it steers.
// Assumes all inputs synchronous to sys_clk_in and a one-cycle bus port.
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "sys_config_cfg.svh"

module system_configuration #(
  parameter int RESET_DRIVE_CYCLES = `RESET_DRIVE_CYCLES,
  parameter int NUM_CS             = 5,
  parameter int NUM_IRQ            = 4
) (
  input  wire logic                sys_clk_in,
  input  wire logic                reset_n_in,
  input  wire logic [15:0]         reg_addr_in,
  input  wire logic [15:0]         reg_wdata_in,
  input  wire logic                reg_write_in,
  input  wire logic                reg_read_in,
  output logic      [15:0]         reg_rdata_out,
  input  wire logic [15:0]         port_zero_in,
  input  wire logic                external_access_pin_in,
  input  wire logic                end_of_init_instr_in,
  input  wire logic                hold_granted_in,
  output logic                     ext_master_access_out,
  output logic                     visible_mode_out,
  output logic                     ext_periph_enable_out,
  input  wire logic                internal_reset_req_in,
  output logic                     reset_in_pin_out,
  output logic                     reset_in_pin_oe_out,
  input  wire logic                pll_bypass_in,
  input  wire logic                crystal_input_in,
  output logic                     cpu_clk_from_pll_out,
  output logic                     pll_off_out,
  input  wire logic                power_down_instr_in,
  input  wire logic                nmi_n_in,
  input  wire logic [NUM_IRQ-1:0]  fast_ext_irq_pin_in,
  input  wire logic [NUM_IRQ-1:0]  fast_ext_irq_en_in,
  output logic                     power_down_out,
  input  wire logic                ale_in,
  input  wire logic [NUM_CS-1:0]   cs_decode_in,
  output logic      [NUM_CS-1:0]   chip_select_lines_out,
  input  wire logic                write_strobe_in,
  input  wire logic                write_low_strobe_in,
  input  wire logic                write_high_strobe_in,
  input  wire logic                byte_high_enable_in,
  output logic                     write_pin_out,
  output logic                     byte_high_enable_pin_out,
  output logic                     byte_high_enable_pin_oe_out,
  output logic                     clock_output_enable_out,
  input  wire logic [23:0]         mem_addr_in,
  output logic                     internal_mem_hit_out,
  output logic                     save_code_segment_out,
  output logic      [10:0]         stack_words_out
);

  localparam int OSC_CYCLES = `OSC_TIMEOUT_CYCLES;

  sys_config_pkg::sys_cfg_s  cfg;
  sys_config_pkg::pd_state_e pd_state;
  sys_config_pkg::pd_state_e next_pd_state;
  logic        locked;
  logic        cfg_hit;
  logic [10:0] rst_cnt;
  logic [7:0]  osc_cnt;
  logic        xtal_q;
  logic        osc_failed;
  logic        ale_q;
  logic        irq_active;

  // Maps the stack field code to a depth in words.
  function automatic logic [10:0] stack_words(input logic [2:0] code);
    logic [10:0] words;
    words = 11'h400;
    if (code < 3'h6) begin
      words = 11'h020 << code;
    end
    return words;
  endfunction

  // Checks an address against the 32 KB internal area in a segment.
  function automatic logic in_mem_area(input logic [23:0] addr,
                                       input logic        seg);
    return (addr[23:16] == {7'h00, seg}) &&
           (addr[15:0] <= `MEM_AREA_LAST);
  endfunction

  assign cfg_hit = (reg_addr_in == `SYS_CONFIG_OFFSET);

  // Straps are taken while reset is held, so the released value is the
  // level present at the last reset edge.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      cfg <= `SYS_CONFIG_RESET;
      cfg.internal_mem_enable <= external_access_pin_in; // R01 R17
      cfg.byte_high_disable <=
        ~port_zero_in[`STRAP_BUS_WIDTH_BIT]; // R01 R16
      cfg.write_strobe_config <=
        ~port_zero_in[`STRAP_WRC_BIT]; // R01 R14
    end else if (reg_write_in && cfg_hit && !locked) begin // R02
      cfg <= (reg_wdata_in & `SYS_CONFIG_WRITE_MASK) |
             (cfg & ~`SYS_CONFIG_WRITE_MASK);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      locked <= 1'b0;
    end else if (end_of_init_instr_in) begin
      locked <= 1'b1; // R02
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_read_in && cfg_hit) begin
      reg_rdata_out <= cfg;
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  assign ext_master_access_out = cfg.ext_periph_share &&
                                 cfg.ext_periph_enable &&
                                 hold_granted_in; // R03
  assign visible_mode_out      = cfg.visible_mode; // R04
  assign ext_periph_enable_out = cfg.ext_periph_enable; // R05

  // The pin drive outlives the internal reset request it answers.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rst_cnt <= 11'h000;
    end else if (internal_reset_req_in && cfg.bidir_reset_enable) begin
      rst_cnt <= 11'(RESET_DRIVE_CYCLES); // R07
    end else if (rst_cnt != 11'h000) begin
      rst_cnt <= rst_cnt - 11'h001;
    end
  end

  assign reset_in_pin_out    = 1'b0;
  assign reset_in_pin_oe_out = (rst_cnt != 11'h000); // R06 R07

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      xtal_q <= 1'b0;
    end else begin
      xtal_q <= crystal_input_in;
    end
  end

  // Once the crystal is lost the PLL clock is kept until reset or until the watchdog disable bit is set.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      osc_cnt    <= 8'h00;
      osc_failed <= 1'b0;
    end else if (cfg.osc_watchdog_disable || !pll_bypass_in ||
                 (xtal_q != crystal_input_in)) begin
      osc_cnt <= 8'h00;
    end else if (osc_cnt >= 8'(OSC_CYCLES - 1)) begin
      osc_failed <= 1'b1; // R08
    end else begin
      osc_cnt <= osc_cnt + 8'h01;
    end
  end

  assign cpu_clk_from_pll_out = !pll_bypass_in ||
    (osc_failed && !cfg.osc_watchdog_disable); // R08 R09
  assign pll_off_out = pll_bypass_in && cfg.osc_watchdog_disable; // R09

  assign irq_active = |(fast_ext_irq_pin_in & fast_ext_irq_en_in);

  always_comb begin
    next_pd_state = pd_state;
    case (pd_state)
      sys_config_pkg::PD_RUN: begin
        if (power_down_instr_in) begin
          if (cfg.power_down_config) begin
            if (!irq_active) begin
              next_pd_state = sys_config_pkg::PD_DOWN; // R11
            end
          end else if (!nmi_n_in) begin
            next_pd_state = sys_config_pkg::PD_DOWN; // R10
          end
        end
      end
      sys_config_pkg::PD_DOWN: begin
        if (cfg.power_down_config && irq_active) begin
          next_pd_state = sys_config_pkg::PD_RUN; // R11
        end
      end
      default: next_pd_state = sys_config_pkg::PD_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pd_state <= sys_config_pkg::PD_RUN;
    end else begin
      pd_state <= next_pd_state;
    end
  end

  assign power_down_out = (pd_state == sys_config_pkg::PD_DOWN);

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ale_q <= 1'b0;
    end else begin
      ale_q <= ale_in;
    end
  end

  // Half a clock cannot be made here, so the latch delay is one cycle.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      chip_select_lines_out <= '0;
    end else if (cfg.chip_select_config || (ale_in && !ale_q)) begin
      chip_select_lines_out <= cs_decode_in; // R12
    end
  end

  assign write_pin_out = cfg.write_strobe_config ?
                         write_low_strobe_in : write_strobe_in; // R13
  assign byte_high_enable_pin_out = cfg.write_strobe_config ?
    write_high_strobe_in : byte_high_enable_in; // R13
  assign byte_high_enable_pin_oe_out = !cfg.byte_high_disable; // R16
  assign clock_output_enable_out = cfg.clock_output_enable; // R15
  assign internal_mem_hit_out = cfg.internal_mem_enable &&
    in_mem_area(mem_addr_in, cfg.internal_mem_segment_sel); // R17 R19
  assign save_code_segment_out = !cfg.segmentation_disable; // R18
  assign stack_words_out = stack_words(cfg.stack_size_sel); // R20 R21

  chk_lock_holds: assert property ( // R02
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    locked |=> $stable(cfg))
    else $error("Configuration changed while locked.");

  chk_write_takes: assert property ( // R02
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (reg_write_in && cfg_hit && !locked) |=>
      cfg.ext_periph_share == $past(reg_wdata_in[0]))
    else $error("Unlocked write not stored.");

  chk_strap_write_strobe_config: assert property ( // R14
    @(posedge sys_clk_in)
    !reset_n_in |=> cfg.write_strobe_config ==
      !$past(port_zero_in[`STRAP_WRC_BIT]))
    else $error("Write config strap not inverted.");

  chk_rst_drive: assert property ( // R07
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (internal_reset_req_in && cfg.bidir_reset_enable) |=>
      reset_in_pin_oe_out [*8])
    else $error("Reset pin not driven after request.");

  chk_rst_quiet: assert property ( // R06
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    ($past(rst_cnt) == 11'h000 && !$past(internal_reset_req_in)) |->
      !reset_in_pin_oe_out)
    else $error("Reset pin driven without cause.");

  chk_osc_switch: assert property ( // R08
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (pll_bypass_in && !cfg.osc_watchdog_disable &&
     (xtal_q == crystal_input_in) &&
     (osc_cnt == 8'(OSC_CYCLES - 1))) |=> osc_failed)
    else $error("Quiet crystal did not select the PLL clock.");

  chk_pd_nmi: assert property ( // R10
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (!power_down_out && power_down_instr_in &&
     !cfg.power_down_config && nmi_n_in) |=> !power_down_out)
    else $error("Power-down entered with NMI high.");

  chk_pd_sticky: assert property ( // R10
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (power_down_out && !cfg.power_down_config) |=> power_down_out)
    else $error("Power-down left without reset.");

  chk_pd_wake: assert property ( // R11
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (power_down_out && cfg.power_down_config && irq_active) |=>
      !power_down_out)
    else $error("Enabled interrupt did not wake.");

  chk_cs_latch: assert property ( // R12
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (!cfg.chip_select_config && !(ale_in && !ale_q)) |=>
      $stable(chip_select_lines_out))
    else $error("Latched chip select moved without ALE.");

  cov_locked_write: cover property (
    @(posedge sys_clk_in) locked && reg_write_in && cfg_hit);
  cov_pd_wake: cover property (
    @(posedge sys_clk_in) power_down_out ##1 !power_down_out);
  cov_rst_drive: cover property (
    @(posedge sys_clk_in) $fell(reset_in_pin_oe_out));

endmodule

// File: tb/tb_system_configuration.sv
// Self-checking bench for the system configuration register block.
// Assumes the block alone, its ports driven directly by this bench.
`timescale 1ns/1ns
`include "sys_config_cfg.svh"

module tb_system_configuration;
  localparam logic [15:0] ADDR = `SYS_CONFIG_OFFSET;
  logic        sys_clk_in             = 1'b0;
  logic        reset_n_in             = 1'b0;
  logic [15:0] reg_addr_in            = 16'h0000;
  logic [15:0] reg_wdata_in           = 16'h0000;
  logic        reg_write_in           = 1'b0;
  logic        reg_read_in            = 1'b0;
  logic [15:0] port_zero_in           = 16'h0000;
  logic        external_access_pin_in = 1'b1;
  logic        end_of_init_instr_in   = 1'b0;
  logic        hold_granted_in        = 1'b0;
  logic        internal_reset_req_in  = 1'b0;
  logic        pll_bypass_in          = 1'b0;
  logic        crystal_input_in       = 1'b0;
  logic        power_down_instr_in    = 1'b0;
  logic        nmi_n_in               = 1'b1;
  logic [3:0]  fast_ext_irq_pin_in    = 4'h0;
  logic [3:0]  fast_ext_irq_en_in     = 4'h0;
  logic        ale_in                 = 1'b0;
  logic [4:0]  cs_decode_in           = 5'h00;
  logic        write_strobe_in        = 1'b0;
  logic        write_low_strobe_in    = 1'b1;
  logic        write_high_strobe_in   = 1'b0;
  logic        byte_high_enable_in    = 1'b1;
  logic [23:0] mem_addr_in            = 24'h000000;
  logic [15:0] reg_rdata_out;
  logic [4:0]  chip_select_lines_out;
  logic [10:0] stack_words_out;
  logic        ext_master_access_out, visible_mode_out, ext_periph_enable_out;
  logic        reset_in_pin_out, reset_in_pin_oe_out, cpu_clk_from_pll_out;
  logic        pll_off_out, power_down_out, write_pin_out;
  logic        byte_high_enable_pin_out, byte_high_enable_pin_oe_out;
  logic        clock_output_enable_out, internal_mem_hit_out;
  logic        save_code_segment_out;
  logic        osc_run                = 1'b0;
  int          mismatches             = 0;
  int          tests_run              = 0;

  system_configuration #(.RESET_DRIVE_CYCLES(8)) i_system_configuration (
    .sys_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .port_zero_in, .external_access_pin_in,
    .end_of_init_instr_in, .hold_granted_in, .ext_master_access_out,
    .visible_mode_out, .ext_periph_enable_out, .internal_reset_req_in,
    .reset_in_pin_out, .reset_in_pin_oe_out, .pll_bypass_in,
    .crystal_input_in, .cpu_clk_from_pll_out, .pll_off_out,
    .power_down_instr_in, .nmi_n_in, .fast_ext_irq_pin_in,
    .fast_ext_irq_en_in, .power_down_out, .ale_in, .cs_decode_in,
    .chip_select_lines_out, .write_strobe_in, .write_low_strobe_in,
    .write_high_strobe_in, .byte_high_enable_in, .write_pin_out,
    .byte_high_enable_pin_out, .byte_high_enable_pin_oe_out,
    .clock_output_enable_out, .mem_addr_in, .internal_mem_hit_out,
    .save_code_segment_out, .stack_words_out);

  always #4 sys_clk_in = ~sys_clk_in;

  // A running crystal toggles every cycle so the watchdog sees activity.
  always @(posedge sys_clk_in) begin
    if (osc_run) crystal_input_in <= ~crystal_input_in;
  end

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_write_in <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_read_in <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata_out);
  endtask

  task automatic pulse(input int which);
    @(posedge sys_clk_in);
    case (which)
      0: power_down_instr_in <= 1'b1;
      1: end_of_init_instr_in <= 1'b1;
      default: internal_reset_req_in <= 1'b1;
    endcase
    @(posedge sys_clk_in);
    power_down_instr_in <= 1'b0;
    end_of_init_instr_in <= 1'b0;
    internal_reset_req_in <= 1'b0;
    #1;
  endtask

  task automatic do_reset(input logic [15:0] p0, input logic ea);
    @(posedge sys_clk_in);
    reset_n_in <= 1'b0;
    port_zero_in <= p0;
    external_access_pin_in <= ea;
    repeat (20) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    #1;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end

  initial begin
    do_reset(16'h0000, 1'b1);
    rd(ADDR, 16'h0680);
    chk("write pin", 16'h0001, 16'(write_pin_out));
    chk("bhe pin", 16'h0000, 16'(byte_high_enable_pin_out));
    chk("bhe oe", 16'h0000, 16'(byte_high_enable_pin_oe_out));
    wr(ADDR, 16'h0000);
    chk("write pin", 16'h0000, 16'(write_pin_out));
    chk("bhe pin", 16'h0001, 16'(byte_high_enable_pin_out));
    rd(ADDR, 16'h0600);
    rd(16'hFF14, 16'h0000);
    mem_addr_in <= 24'h007FFF;
    cycles(1);
    chk("mem hit", 16'h0001, 16'(internal_mem_hit_out));
    mem_addr_in <= 24'h010000;
    cycles(1);
    chk("mem hit", 16'h0000, 16'(internal_mem_hit_out));
    wr(ADDR, 16'h1000);
    chk("mem hit", 16'h0001, 16'(internal_mem_hit_out));
    mem_addr_in <= 24'h008000;
    cycles(1);
    chk("mem hit", 16'h0000, 16'(internal_mem_hit_out));
    hold_granted_in <= 1'b1;
    wr(ADDR, 16'h0906);
    rd(ADDR, 16'h0F06);
    chk("visible", 16'h0001, 16'(visible_mode_out));
    chk("xp enable", 16'h0001, 16'(ext_periph_enable_out));
    chk("clk out", 16'h0001, 16'(clock_output_enable_out));
    chk("save csp", 16'h0000, 16'(save_code_segment_out));
    chk("ext master", 16'h0000, 16'(ext_master_access_out));
    wr(ADDR, 16'h0005);
    chk("ext master", 16'h0001, 16'(ext_master_access_out));
    chk("visible", 16'h0000, 16'(visible_mode_out));
    chk("clk out", 16'h0000, 16'(clock_output_enable_out));
    chk("save csp", 16'h0001, 16'(save_code_segment_out));
    hold_granted_in <= 1'b0;
    cycles(1);
    chk("ext master", 16'h0000, 16'(ext_master_access_out));
    for (int c = 0; c < 8; c++) begin
      wr(ADDR, {c[2:0], 13'h0000});
      chk("stack", (c < 6) ? (16'h0020 << c) : 16'h0400,
          {5'h00, stack_words_out});
    end
    wr(ADDR, 16'h0000);
    pulse(2);
    chk("rst oe", 16'h0000, 16'(reset_in_pin_oe_out));
    wr(ADDR, 16'h0008);
    pulse(2);
    chk("rst oe", 16'h0001, 16'(reset_in_pin_oe_out));
    chk("rst pin", 16'h0000, 16'(reset_in_pin_out));
    cycles(7);
    chk("rst oe", 16'h0001, 16'(reset_in_pin_oe_out));
    cycles(1);
    chk("rst oe", 16'h0000, 16'(reset_in_pin_oe_out));
    cs_decode_in <= 5'h0A;
    wr(ADDR, 16'h0000);
    chk("cs", 16'h0000, 16'(chip_select_lines_out));
    ale_in <= 1'b1;
    cycles(2);
    chk("cs", 16'h000A, 16'(chip_select_lines_out));
    cs_decode_in <= 5'h15;
    cycles(2);
    chk("cs", 16'h000A, 16'(chip_select_lines_out));
    wr(ADDR, 16'h0040);
    cycles(1);
    chk("cs", 16'h0015, 16'(chip_select_lines_out));
    wr(ADDR, 16'h0020);
    fast_ext_irq_en_in <= 4'h2;
    fast_ext_irq_pin_in <= 4'h2;
    pulse(0);
    chk("pd", 16'h0000, 16'(power_down_out));
    fast_ext_irq_pin_in <= 4'h1;
    pulse(0);
    chk("pd", 16'h0001, 16'(power_down_out));
    fast_ext_irq_pin_in <= 4'h3;
    cycles(2);
    chk("pd", 16'h0000, 16'(power_down_out));
    chk("cpu pll", 16'h0001, 16'(cpu_clk_from_pll_out));
    pll_bypass_in <= 1'b1;
    osc_run <= 1'b1;
    wr(ADDR, 16'h0010);
    chk("pll off", 16'h0001, 16'(pll_off_out));
    chk("cpu pll", 16'h0000, 16'(cpu_clk_from_pll_out));
    wr(ADDR, 16'h0000);
    cycles(200);
    chk("cpu pll", 16'h0000, 16'(cpu_clk_from_pll_out));
    chk("pll off", 16'h0000, 16'(pll_off_out));
    osc_run <= 1'b0;
    cycles(130);
    chk("cpu pll", 16'h0001, 16'(cpu_clk_from_pll_out));
    pulse(0);
    chk("pd", 16'h0000, 16'(power_down_out));
    nmi_n_in <= 1'b0;
    pulse(0);
    chk("pd", 16'h0001, 16'(power_down_out));
    wr(ADDR, 16'h0005);
    pulse(1);
    wr(ADDR, 16'hF9FA);
    rd(ADDR, 16'h0605);
    chk("pd", 16'h0001, 16'(power_down_out));
    do_reset(16'h00A0, 1'b0);
    chk("pd", 16'h0000, 16'(power_down_out));
    rd(ADDR, 16'h0000);
    chk("bhe oe", 16'h0001, 16'(byte_high_enable_pin_oe_out));
    mem_addr_in <= 24'h000000;
    cycles(1);
    chk("mem hit", 16'h0000, 16'(internal_mem_hit_out));
    wr(ADDR, 16'h0081);
    rd(ADDR, 16'h0081);
    give_verdict();
  end
endmodule
